// ===== hdl/lcd_cmd_pkg.sv
/*
  Shared constants and types for the character display command decoder:
  opcode fields, reset values, busy timing, blink timing and bus carriers.
  Assumes a single 20 MHz master clock domain; no header include needed.
*/
package lcd_cmd_pkg;

  // master clock and time figures
  localparam longint CLOCK_HZ           = 64'd20000000;  // master clock rate
  localparam longint BLINK_PERIOD_MS    = 64'd300;       // full blink period
  localparam longint BLINK_HALF_CYCLES  = (BLINK_PERIOD_MS * CLOCK_HZ) / 64'd2000;
  localparam int     CLEAR_BUSY_CYCLES  = 34;            // busy after a clear
  localparam int     RESET_BUSY_CYCLES  = 2;             // busy after internal reset
  localparam int     BUSY_CNT_W         = 6;             // busy counter width

  // opcode prefixes, compared against the leading bits of a command byte
  localparam logic [7:0] OP_CLEAR       = 8'h01;  // display clear
  localparam logic [6:0] OP_HOME        = 7'h01;  // cursor home, bit 0 ignored
  localparam logic [5:0] OP_ENTRY_LINE  = 6'h01;  // entry mode / line mode
  localparam logic [4:0] OP_CONTROL     = 5'h01;  // control one / control two
  localparam logic [3:0] OP_SHIFT_POWER = 4'h1;   // shift / power control
  localparam logic [2:0] OP_FUNCTION    = 3'h1;   // function set
  localparam logic [1:0] OP_GLYPH_SEG   = 2'h1;   // glyph or segment address
  localparam logic [1:0] OP_TEXT_ADDR   = 2'h2;   // text address set

  // field positions inside command and status bytes
  localparam int FUNC_EXT_BIT   = 2;  // extension_select in function set
  localparam int SHIFT_SC_BIT   = 3;  // display (1) or cursor (0)
  localparam int SHIFT_RL_BIT   = 2;  // right (1) or left (0)
  localparam int ACL_BIT        = 0;  // internal reset in power control
  localparam int STATUS_BUSY    = 7;  // busy flag position in status byte

  // memories and geometry
  localparam int TEXT_DEPTH     = 32;
  localparam int GLYPH_DEPTH    = 64;
  localparam int SEG_DEPTH      = 16;
  localparam int LINE_LEN       = 16;
  localparam int CURSOR_ROW     = 7;   // eighth dot row of the cell
  localparam int MARKER_ROW     = 8;   // extra common slot
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [5:0] TEXT_MASK  = 6'h1F;
  localparam logic [5:0] GLYPH_MASK = 6'h3F;
  localparam logic [5:0] SEG_MASK   = 6'h0F;

  // common line counts for each duty
  localparam logic [4:0] COMMONS_ONE = 5'h08;
  localparam logic [4:0] COMMONS_TWO = 5'h10;

  typedef enum logic [1:0] {
    SEL_TEXT  = 2'h0,
    SEL_GLYPH = 2'h1,
    SEL_SEG   = 2'h2
  } ram_sel_t;

  typedef enum logic [2:0] {
    ST_READY = 3'h1,
    ST_CLEAR = 3'h2,
    ST_RESET = 3'h4
  } busy_state_t;

  typedef struct packed {
    logic       write;   // one-cycle write strobe
    logic       read;    // one-cycle read strobe
    logic       regSel;  // register_select_line: 1 data, 0 command/status
    logic [7:0] data;    // byte written by the host
  } host_req_t;

  typedef struct packed {
    logic       line;    // 0 first line, 1 second line
    logic [3:0] column;  // character column on the panel
    logic [3:0] row;     // dot row 0..7, 8 is the marker slot
  } scan_t;

  typedef struct packed {
    logic extensionSelect;
    logic incrementMode;
    logic shiftOnWrite;
    logic lineCountSelect;
    logic displayOn;
    logic cursorOn;
    logic blinkOn;
    logic markerDuty;
    logic inverseVideo;
    logic allDotsLit;
  } disp_flags_t;

  localparam disp_flags_t FLAGS_RESET = '{
    extensionSelect: 1'b0, incrementMode: 1'b1, shiftOnWrite: 1'b0,
    lineCountSelect: 1'b0, displayOn: 1'b0, cursorOn: 1'b0, blinkOn: 1'b0,
    markerDuty: 1'b0, inverseVideo: 1'b0, allDotsLit: 1'b0};

endpackage : lcd_cmd_pkg

// ===== hdl/lcd_text_command_decoder.sv
/*
  Command decoder and display state of a character dot-matrix driver:
  host byte port with register select, text/glyph/segment memories,
  address counter, busy timing, display flags, shift offset and the
  per-dot output stage of the panel scan.
  Assumes host strobes and scan inputs are synchronous to clock, and an
  outside font store returns glyphRowDots for charCodeOut in the same cycle.
  // Operation
  // - data write stores into selected memory
  // - data read returns selected memory byte
  // - each data access steps address counter
  // - clear fills text with spaces, address zero
  // - clear cancels shift, forces increment mode
  // - clear holds busy for 34 clocks
  // - only clear and internal reset raise busy
  // - home zeroes address, cancels shift only
  // - increment flag chooses step direction
  // - shift-on-write moves display on text writes
  // - extension bit selects shared opcode meaning
  // - line flag picks two or one line
  // - display-on gates all dots, keeps text
  // - cursor is five dots on row eight
  // - blink inverts cursor cell periodically
  // - extended flags persist after extension cleared
  // - marker duty adds common fed by segments
  // - reverse inverts dots, all-on overrides it
  // - shift command moves cursor or display
  // - cursor carries into line two, lines shift together
  // - display shift leaves address counter alone
  // - status read gives busy and address
  // - commands ignored while busy
  // - extension bit stored by function set
  // - reset restores default flags
*/
`timescale 1ns/1ps
`default_nettype none

module lcd_text_command_decoder
  import lcd_cmd_pkg::*;
#(
  parameter longint BLINK_HALF = lcd_cmd_pkg::BLINK_HALF_CYCLES  // shorten in simulation
) (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire lcd_cmd_pkg::host_req_t  hostReq,
  input  wire lcd_cmd_pkg::scan_t      scanPos,
  input  wire logic [4:0]              glyphRowDots,
  output logic [7:0]                   hostDataOut,
  output logic                         hostReadValid,
  output logic                         busyFlag,
  output logic [7:0]                   charCodeOut,
  output logic [4:0]                   dotsOut,
  output logic [4:0]                   commonCount,
  output lcd_cmd_pkg::disp_flags_t     flagsOut
);

  import lcd_cmd_pkg::*;

  // reset release synchroniser, asynchronous assert
  logic rstMeta_ff;  // first stage, read only by the second
  logic rstSync_ff;  // active high once released
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  wire logic rst = ~rstSync_ff;  // internal active-high reset

  // address stepping shared by data access and cursor moves
  function automatic logic [5:0] stepAddr(input logic [5:0] a, input ram_sel_t s, input logic up);
    logic [5:0] sum;
    sum = up ? a + 6'h01 : a - 6'h01;
    case (s)
      SEL_TEXT:  stepAddr = sum & TEXT_MASK;
      SEL_GLYPH: stepAddr = sum & GLYPH_MASK;
      default:   stepAddr = sum & SEG_MASK;
    endcase
  endfunction : stepAddr

  // state
  busy_state_t state_ff;                  // busy sequencer
  logic [BUSY_CNT_W-1:0] busyCnt_ff;      // cycles left busy
  disp_flags_t flags_ff;                  // stored mode flags
  ram_sel_t    sel_ff;                    // memory chosen by last address set
  logic [5:0]  ac_ff;                     // address counter
  logic [3:0]  shift_ff;                  // display offset, wraps at 16
  logic [7:0]  textRam  [TEXT_DEPTH];     // character codes
  logic [7:0]  glyphRam [GLYPH_DEPTH];    // user glyph rows
  logic [7:0]  segment_ram   [SEG_DEPTH];      // marker segment data
  logic [7:0]  hostDataOut_ff;
  logic        hostReadValid_ff;
  logic        busyFlag_ff;

  // request decode
  wire logic [7:0] d       = hostReq.data;
  wire logic       busy    = (state_ff != ST_READY);
  wire logic       ext     = flags_ff.extensionSelect;
  wire logic       cmdWr   = hostReq.write & ~hostReq.regSel & ~busy;
  wire logic       dataWr  = hostReq.write &  hostReq.regSel & ~busy;
  wire logic       dataRd  = hostReq.read  &  hostReq.regSel & ~busy;
  wire logic       statRd  = hostReq.read  & ~hostReq.regSel;

  // shared opcodes split by the extension bit
  wire logic cmdClear  = cmdWr & (d == OP_CLEAR);
  wire logic cmdHome   = cmdWr & (d[7:1] == OP_HOME);
  wire logic cmdEntry  = cmdWr & (d[7:2] == OP_ENTRY_LINE) & ~ext;
  wire logic cmdLine   = cmdWr & (d[7:2] == OP_ENTRY_LINE) &  ext;
  wire logic cmdCtl1   = cmdWr & (d[7:3] == OP_CONTROL) & ~ext;
  wire logic cmdCtl2   = cmdWr & (d[7:3] == OP_CONTROL) &  ext;
  wire logic cmdShift  = cmdWr & (d[7:4] == OP_SHIFT_POWER) & ~ext;
  wire logic cmdIntRst = cmdWr & (d[7:4] == OP_SHIFT_POWER) & ext & d[ACL_BIT];
  wire logic cmdFunc   = cmdWr & (d[7:5] == OP_FUNCTION);
  wire logic cmdGlyphA = cmdWr & (d[7:6] == OP_GLYPH_SEG) & ~ext;
  wire logic cmdSegA   = cmdWr & (d[7:6] == OP_GLYPH_SEG) &  ext;
  wire logic cmdTextA  = cmdWr & (d[7:6] == OP_TEXT_ADDR) & ~ext;

  // data access targets
  wire logic textWr    = dataWr & (sel_ff == SEL_TEXT);
  wire logic dataAcc   = dataWr | dataRd;
  wire logic [5:0] acStep = stepAddr(ac_ff, sel_ff, flags_ff.incrementMode);
  wire logic [7:0] ramRead =
      (sel_ff == SEL_TEXT)  ? textRam[ac_ff[4:0]] :
      (sel_ff == SEL_GLYPH) ? glyphRam[ac_ff] : segment_ram[ac_ff[3:0]];

  // shift command decode
  wire logic shiftDisp = cmdShift &  d[SHIFT_SC_BIT];
  wire logic shiftCurs = cmdShift & ~d[SHIFT_SC_BIT];
  wire logic [5:0] acMove = stepAddr(ac_ff, sel_ff, d[SHIFT_RL_BIT]);
  // writing with shift-on-write moves the view with the cursor
  wire logic autoShift = textWr & flags_ff.shiftOnWrite;

  // busy sequencer: only clear and internal reset leave ready
  busy_state_t nxt_state;
  logic [BUSY_CNT_W-1:0] nxt_busyCnt;
  always_comb begin
    nxt_state   = state_ff;
    nxt_busyCnt = busyCnt_ff;
    case (state_ff)
      ST_READY: begin
        if (cmdClear) begin
          nxt_state   = ST_CLEAR;
          nxt_busyCnt = BUSY_CNT_W'(CLEAR_BUSY_CYCLES - 1);
        end else if (cmdIntRst) begin
          nxt_state   = ST_RESET;
          nxt_busyCnt = BUSY_CNT_W'(RESET_BUSY_CYCLES - 1);
        end
      end
      ST_CLEAR, ST_RESET: begin
        if (busyCnt_ff == '0) begin
          nxt_state = ST_READY;
        end else begin
          nxt_busyCnt = busyCnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state   = ST_READY;
        nxt_busyCnt = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff    <= ST_READY;
      busyCnt_ff  <= '0;
      busyFlag_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      busyCnt_ff  <= nxt_busyCnt;
      busyFlag_ff <= (nxt_state != ST_READY);  // mirrors busy for the busyFlag output
    end
  end

  // mode flags; extended flags keep their value when extension drops
  disp_flags_t nxt_flags;
  always_comb begin
    nxt_flags = flags_ff;
    if (cmdIntRst) begin
      nxt_flags = FLAGS_RESET;
    end else if (cmdClear) begin
      nxt_flags.incrementMode = 1'b1;
    end else if (cmdEntry) begin
      nxt_flags.incrementMode = d[1];
      nxt_flags.shiftOnWrite  = d[0];
    end else if (cmdLine) begin
      nxt_flags.lineCountSelect = d[0];
    end else if (cmdCtl1) begin
      nxt_flags.displayOn = d[2];
      nxt_flags.cursorOn  = d[1];
      nxt_flags.blinkOn   = d[0];
    end else if (cmdCtl2) begin
      nxt_flags.markerDuty   = d[2];
      nxt_flags.inverseVideo = d[1];
      nxt_flags.allDotsLit   = d[0];
    end else if (cmdFunc) begin
      nxt_flags.extensionSelect = d[FUNC_EXT_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_ff <= FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // address counter, selected memory and display offset
  logic [5:0] nxt_ac;
  ram_sel_t   nxt_sel;
  logic [3:0] nxt_shift;
  always_comb begin
    nxt_ac    = ac_ff;
    nxt_sel   = sel_ff;
    nxt_shift = shift_ff;
    if (cmdClear | cmdHome | cmdIntRst) begin
      nxt_ac    = '0;
      nxt_sel   = SEL_TEXT;
      nxt_shift = '0;
    end else if (cmdTextA) begin
      nxt_ac  = {1'b0, d[4:0]};
      nxt_sel = SEL_TEXT;
    end else if (cmdGlyphA) begin
      nxt_ac  = d[5:0];
      nxt_sel = SEL_GLYPH;
    end else if (cmdSegA) begin
      nxt_ac  = {2'h0, d[3:0]};
      nxt_sel = SEL_SEG;
    end else if (shiftCurs) begin
      nxt_ac = acMove;  // carry 15 to 16 falls out of the step
    end else if (shiftDisp) begin
      // left shows later columns; address counter untouched
      nxt_shift = d[SHIFT_RL_BIT] ? shift_ff - 4'h1 : shift_ff + 4'h1;
    end else if (dataAcc) begin
      nxt_ac = acStep;
      if (autoShift) begin
        nxt_shift = flags_ff.incrementMode ? shift_ff + 4'h1 : shift_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ac_ff    <= '0;
      sel_ff   <= SEL_TEXT;
      shift_ff <= '0;
    end else begin
      ac_ff    <= nxt_ac;
      sel_ff   <= nxt_sel;
      shift_ff <= nxt_shift;
    end
  end

  // text memory: clear fills every cell at once, busy covers the rest
  genvar gi;
  generate
    for (gi = 0; gi < TEXT_DEPTH; gi++) begin : g_text
      wire logic hit = textWr & (ac_ff[4:0] == 5'(gi));
      always_ff @(posedge clock) begin
        if (rst | cmdClear) begin
          textRam[gi] <= SPACE_CODE;
        end else if (hit) begin
          textRam[gi] <= d;
        end
      end
    end
  endgenerate

  // glyph and segment memories hold no reset; contents start undefined
  always_ff @(posedge clock) begin
    if (dataWr & (sel_ff == SEL_GLYPH)) begin
      glyphRam[ac_ff] <= d;
    end
  end

  always_ff @(posedge clock) begin
    if (dataWr & (sel_ff == SEL_SEG)) begin
      segment_ram[ac_ff[3:0]] <= d;
    end
  end

  // host answers one cycle after the read strobe
  wire logic [7:0] statusByte = {busy, 1'b0, ac_ff};
  always_ff @(posedge clock) begin
    if (rst) begin
      hostDataOut_ff   <= '0;
      hostReadValid_ff <= 1'b0;
    end else begin
      hostReadValid_ff <= dataRd | statRd;
      if (statRd) begin
        hostDataOut_ff <= statusByte;
      end else if (dataRd) begin
        hostDataOut_ff <= ramRead;
      end
    end
  end

  // blink timebase runs from the master clock, so it scales with its rate
  logic [31:0] blinkCnt_ff;
  logic        blinkPhase_ff;
  wire logic   blinkWrap = (blinkCnt_ff == 32'(BLINK_HALF - 1));
  always_ff @(posedge clock) begin
    if (rst) begin
      blinkCnt_ff   <= '0;
      blinkPhase_ff <= 1'b0;
    end else begin
      blinkCnt_ff   <= blinkWrap ? '0 : blinkCnt_ff + 32'h1;
      blinkPhase_ff <= blinkPhase_ff ^ blinkWrap;
    end
  end

  // scan stage one: same offset applied to both lines
  wire logic [3:0] viewCol   = scanPos.column + shift_ff;
  wire logic [4:0] scanIndex = {scanPos.line, viewCol};
  wire logic       cursorHit = (sel_ff == SEL_TEXT) & (scanIndex == ac_ff[4:0]);
  wire logic       markerRow = flags_ff.markerDuty & (scanPos.row == 4'(MARKER_ROW));
  logic [7:0] charCode_ff;
  logic       cursorHit_ff;
  logic       marker_ff;
  logic [3:0] row_ff;
  logic [4:0] segDots_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      charCode_ff  <= SPACE_CODE;
      cursorHit_ff <= 1'b0;
      marker_ff    <= 1'b0;
      row_ff       <= '0;
      segDots_ff   <= '0;
    end else begin
      charCode_ff  <= textRam[scanIndex];
      cursorHit_ff <= cursorHit;
      marker_ff    <= markerRow;
      row_ff       <= scanPos.row;
      segDots_ff   <= segment_ram[scanPos.column][4:0];
    end
  end

  // scan stage two: build the dot row, last override wins
  logic [4:0] nxt_dots;
  always_comb begin
    nxt_dots = marker_ff ? segDots_ff : glyphRowDots;
    if (!marker_ff & cursorHit_ff & flags_ff.cursorOn & (row_ff == 4'(CURSOR_ROW))) begin
      nxt_dots = 5'h1F;
    end
    if (!marker_ff & cursorHit_ff & flags_ff.blinkOn & blinkPhase_ff) begin
      nxt_dots = ~nxt_dots;
    end
    if (flags_ff.inverseVideo) begin
      nxt_dots = ~nxt_dots;
    end
    if (flags_ff.allDotsLit) begin
      nxt_dots = 5'h1F;
    end
    if (!flags_ff.displayOn) begin
      nxt_dots = 5'h00;
    end
  end

  // common count: one or two lines, plus the marker slot
  wire logic [4:0] baseCommons = flags_ff.lineCountSelect ? COMMONS_ONE : COMMONS_TWO;
  logic [4:0] dots_ff;
  logic [4:0] commons_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      dots_ff    <= '0;
      commons_ff <= COMMONS_TWO;
    end else begin
      dots_ff    <= nxt_dots;
      commons_ff <= baseCommons + {4'h0, flags_ff.markerDuty};
    end
  end

  // outputs, all straight from flip-flops
  assign hostDataOut   = hostDataOut_ff;
  assign hostReadValid = hostReadValid_ff;
  assign busyFlag      = busyFlag_ff;
  assign charCodeOut   = charCode_ff;
  assign dotsOut       = dots_ff;
  assign commonCount   = commons_ff;
  assign flagsOut      = flags_ff;

endmodule : lcd_text_command_decoder

`default_nettype wire

// ===== testbench/host_model.sv
/*
  Behavioural host processor: single-byte writes and reads on the
  register-select port, strobes raised and dropped at falling edges.
  Assumes the decoder answers reads within three cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model
  import lcd_cmd_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             hostReadValid,
  input  wire logic [7:0]       hostDataOut,
  output var  lcd_cmd_pkg::host_req_t hostReq
);
  initial hostReq = '{write: 1'b0, read: 1'b0, regSel: 1'b0, data: 8'hA5};

  // one-cycle write; the released bus shows the inverse, not the old byte
  task automatic wr(input logic rs, input logic [7:0] d);
    @(negedge clock);
    hostReq = '{write: 1'b1, read: 1'b0, regSel: rs, data: d};
    @(negedge clock);
    hostReq = '{write: 1'b0, read: 1'b0, regSel: ~rs, data: ~d};
  endtask : wr

  // one-cycle read; answer looked for over a bounded window
  task automatic rd(input logic rs, output logic [7:0] q, output logic ok);
    ok = 1'b0;
    q = 8'h00;
    @(negedge clock);
    hostReq = '{write: 1'b0, read: 1'b1, regSel: rs, data: ~hostReq.data};
    @(negedge clock);
    hostReq.read = 1'b0;
    for (int k = 0; k < 3 && !ok; k++) begin
      if (hostReadValid === 1'b1) begin
        ok = 1'b1;
        q = hostDataOut;
      end else @(negedge clock);
    end
  endtask : rd
endmodule : host_model

`default_nettype wire

// ===== testbench/lcd_cmd_props.sv
/*
  Checker for the command decoder: relations between host requests, busy,
  the stored flags, the common count and the final dots.
  Assumes it is bound to the decoder top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module lcd_cmd_props
  import lcd_cmd_pkg::*;
(
  input wire logic                    clock,
  input wire logic                    reset_n,
  input wire lcd_cmd_pkg::host_req_t  hostReq,
  input wire lcd_cmd_pkg::scan_t      scanPos,
  input wire logic [4:0]              glyphRowDots,
  input wire logic [7:0]              hostDataOut,
  input wire logic                    hostReadValid,
  input wire logic                    busyFlag,
  input wire logic [7:0]              charCodeOut,
  input wire logic [4:0]              dotsOut,
  input wire logic [4:0]              commonCount,
  input wire lcd_cmd_pkg::disp_flags_t flagsOut
);
  logic [5:0] busyRun_ff;  // cycles busy has stood high
  wire logic  cmdTake = hostReq.write && !hostReq.regSel && !busyFlag;  // command seen when idle
  wire logic  aclCode = flagsOut.extensionSelect && hostReq.data[7:4] == 4'h1 && hostReq.data[0];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // length of the last busy run, read on its falling edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) busyRun_ff <= 6'h00;
    else busyRun_ff <= busyFlag ? busyRun_ff + 6'h01 : 6'h00;
  end

  read_answer_a: assert property (hostReq.read && !hostReq.regSel |=> hostReadValid && !hostDataOut[6])
    else $error("status read gave no answer");
  clear_busy_a: assert property (cmdTake && !$past(busyFlag) && hostReq.data == OP_CLEAR
      |=> ##[0:1] busyFlag)
    else $error("clear did not raise busy");
  busy_length_a: assert property ($fell(busyFlag) |->
      busyRun_ff == 6'(CLEAR_BUSY_CYCLES) || busyRun_ff == 6'(RESET_BUSY_CYCLES))
    else $error("busy run has wrong length");
  only_clear_busy_a: assert property (cmdTake && !$past(busyFlag) && hostReq.data != OP_CLEAR && !aclCode
      |=> !busyFlag ##1 !busyFlag)
    else $error("busy raised by a plain command");
  entry_mode_a: assert property (cmdTake && !$past(busyFlag) && !flagsOut.extensionSelect
      && hostReq.data[7:2] == OP_ENTRY_LINE |=> flagsOut.incrementMode == $past(hostReq.data[1])
      && flagsOut.shiftOnWrite == $past(hostReq.data[0]))
    else $error("entry mode not taken");
  line_mode_a: assert property (cmdTake && !$past(busyFlag) && flagsOut.extensionSelect
      && hostReq.data[7:2] == OP_ENTRY_LINE |=> flagsOut.lineCountSelect == $past(hostReq.data[0])
      && $stable(flagsOut.incrementMode))
    else $error("line mode not taken");
  clear_incr_a: assert property (cmdTake && !$past(busyFlag) && hostReq.data == OP_CLEAR
      |=> flagsOut.incrementMode && $stable(flagsOut.shiftOnWrite))
    else $error("clear left entry mode wrong");
  ext_store_a: assert property (cmdTake && !$past(busyFlag) && hostReq.data[7:5] == OP_FUNCTION
      |=> flagsOut.extensionSelect == $past(hostReq.data[FUNC_EXT_BIT]))
    else $error("extension bit not stored");
  common_count_a: assert property ($stable(flagsOut) |=> commonCount == ($past(flagsOut.lineCountSelect)
      ? COMMONS_ONE : COMMONS_TWO) + 5'($past(flagsOut.markerDuty)))
    else $error("common count does not follow flags");
  display_off_a: assert property (!flagsOut.displayOn [*3] |-> dotsOut == 5'h00)
    else $error("dots lit while display off");
  all_on_a: assert property ((flagsOut.displayOn && flagsOut.allDotsLit) [*3] |-> dotsOut == 5'h1F)
    else $error("all-on did not light every dot");

  // main scenarios reached
  clear_c: cover property (cmdTake && hostReq.data == OP_CLEAR);
  line_c: cover property (flagsOut.lineCountSelect && flagsOut.markerDuty);
  allon_c: cover property (flagsOut.allDotsLit && flagsOut.inverseVideo);
endmodule : lcd_cmd_props

bind lcd_text_command_decoder lcd_cmd_props props (.clock(clock), .reset_n(reset_n), .hostReq(hostReq),
  .scanPos(scanPos), .glyphRowDots(glyphRowDots), .hostDataOut(hostDataOut), .hostReadValid(hostReadValid),
  .busyFlag(busyFlag), .charCodeOut(charCodeOut), .dotsOut(dotsOut), .commonCount(commonCount),
  .flagsOut(flagsOut));

`default_nettype wire

// ===== testbench/lcd_text_command_decoder_tb.sv
/*
  Self-checking bench: a host model drives the decoder while a small
  reference model (address counter, text copy) predicts every address and text read.
  Assumes the package and the decoder are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module lcd_text_command_decoder_tb;
  import lcd_cmd_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  host_req_t   hostReq;
  scan_t       scanPos = '0;
  logic [4:0]  glyphRowDots = 5'h00;  // font row stand-in
  logic [7:0]  hostDataOut, charCodeOut, q;
  logic        hostReadValid, busyFlag, ok;
  logic [4:0]  dotsOut, commonCount;
  disp_flags_t flagsOut;
  logic [31:0] rnd;
  int          errors = 0, cmp_count = 0, cycles = 0, seed = 32'h8174;
  int          ac = 0, incr = 1, i;   // model address counter and step
  int          mem[TEXT_DEPTH];       // model text memory

  always #25 clock = ~clock;

  // scan position and font row wander randomly, row kept within 0..8
  always @(negedge clock) begin
    rnd = $random(seed);
    scanPos <= '{line: rnd[0], column: rnd[4:1], row: (rnd[8:5] > 4'h8) ? 4'h8 : rnd[8:5]};
    glyphRowDots <= rnd[13:9];
  end

  // a hang ends the run as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  host_model host (.clock(clock), .hostReadValid(hostReadValid), .hostDataOut(hostDataOut), .hostReq(hostReq));

  lcd_text_command_decoder #(.BLINK_HALF(8)) uut (.clock(clock), .reset_n(reset_n), .hostReq(hostReq),
    .scanPos(scanPos), .glyphRowDots(glyphRowDots), .hostDataOut(hostDataOut), .hostReadValid(hostReadValid),
    .busyFlag(busyFlag), .charCodeOut(charCodeOut), .dotsOut(dotsOut), .commonCount(commonCount),
    .flagsOut(flagsOut));

  task automatic stop_test;
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // command byte, one spare cycle so registered outputs settle
  task automatic cmd(input logic [7:0] d);
    host.wr(1'b0, d);
    @(negedge clock);
  endtask : cmd

  // text write, model stepped the way the entry mode says
  task automatic dwr(input logic [7:0] d);
    mem[ac] = d;
    ac = (ac + incr) & 31;
    host.wr(1'b1, d);
  endtask : dwr

  task automatic chk_ac;
    logic [7:0] s;
    host.rd(1'b0, s, ok);
    `CHK(ok, 1'b1)
    `CHK(s[5:0], 6'(ac))
  endtask : chk_ac

  // polling the status byte keeps the host side honest during busy
  task automatic wait_ready;
    logic [7:0] s;
    s = 8'h80;
    for (int k = 0; k < 60 && s[7]; k++) host.rd(1'b0, s, ok);
    `CHK(s[7], 1'b0)
  endtask : wait_ready

  task automatic check_text;
    logic [7:0] d;
    cmd(8'h80);
    for (int k = 0; k < TEXT_DEPTH; k++) begin
      host.rd(1'b1, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, mem[k][7:0])
    end
  endtask : check_text

  initial begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(flagsOut, FLAGS_RESET)
    `CHK(commonCount, COMMONS_TWO)
    // fill text with random bytes, wrap back to 0, read all back
    cmd(8'h80);
    for (i = 0; i < TEXT_DEPTH; i++) begin
      dwr(8'($random(seed)));
    end
    chk_ac();
    check_text();
    chk_ac();
    // decrement, then increment with shift-on-write
    cmd(8'h04);
    incr = -1;
    dwr(8'h41);
    chk_ac();
    cmd(8'h07);
    incr = 1;
    dwr(8'h42);
    chk_ac();
    `CHK(flagsOut.shiftOnWrite, 1'b1)
    // cursor left, right, display left, right; marker line is off here
    for (i = 0; i < 4; i++) begin
      cmd(8'h10 | 8'(i << 2));
      if (i < 2) ac = (ac + ((i == 0) ? -1 : 1)) & 31;
      chk_ac();
    end
    cmd(8'h8F);
    cmd(8'h14);
    ac = 16;
    chk_ac();
    cmd(8'h03);
    ac = 0;
    chk_ac();
    host.rd(1'b1, q, ok);
    ac = 1;
    `CHK(q, mem[0][7:0])
    // clear with decrement set; a command sent while busy must be dropped
    cmd(8'h05);
    cmd(8'h01);
    `CHK(busyFlag, 1'b1)
    cmd(8'h06);
    wait_ready();
    `CHK(flagsOut.incrementMode, 1'b1)
    `CHK(flagsOut.shiftOnWrite, 1'b1)
    ac = 0;
    chk_ac();
    foreach (mem[k]) mem[k] = 32'h20;
    check_text();
    // every scanned cell now holds a space, wherever the scan stands
    `CHK(charCodeOut, SPACE_CODE)
    // extended set: line mode, control two, then back to plain set
    cmd(8'h24);
    `CHK(flagsOut.extensionSelect, 1'b1)
    cmd(8'h05);
    `CHK(flagsOut.lineCountSelect, 1'b1)
    `CHK(flagsOut.incrementMode, 1'b1)
    `CHK(commonCount, COMMONS_ONE)
    cmd(8'h0C);
    `CHK(commonCount, COMMONS_ONE + 5'h01)
    cmd(8'h04);
    `CHK(commonCount, COMMONS_TWO + 5'h01)
    cmd(8'h0B);
    cmd(8'h20);
    `CHK(flagsOut.inverseVideo, 1'b1)
    `CHK(flagsOut.allDotsLit, 1'b1)
    cmd(8'h0F);
    `CHK({flagsOut.displayOn, flagsOut.cursorOn, flagsOut.blinkOn}, 3'h7)
    `CHK(flagsOut.markerDuty, 1'b0)
    repeat (3) @(negedge clock);
    `CHK(dotsOut, 5'h1F)
    cmd(8'h08);
    repeat (3) @(negedge clock);
    `CHK(dotsOut, 5'h00)
    // internal reset restores the defaults after a short busy
    cmd(8'h24);
    cmd(8'h11);
    wait_ready();
    `CHK(flagsOut, FLAGS_RESET)
    stop_test();
  end
endmodule : lcd_text_command_decoder_tb

`default_nettype wire
